/* rtl/isil_top.v */
// status flags, interrupt mask and control bits of the two-wire controller, on AHB-Lite
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "isil_regs.vh"

// How it works
// - bus-active bit 15 sets on start, clears on stop, reset or disable.
// - engaged bit 14 is high while transferring, while stretching, or while the bus is active and master-select is clear.
// - status bits 13 and 12 read zero.
// - stop-seen flag bit 11 sets on a stop and holds until cleared.
// - bit 10 shows the synchronised clock line level.
// - overrun bit 9 sets on a second byte; buffer read clears it.
// - general-call flag bit 8 sets on a general call only when acceptance is on.
// - not-acked flag bit 7 sets on a negative acknowledge while transmitting.
// - arbitration-lost flag bit 6 sets and master-select drops.
// - address-match flag bit 5 sets on an own-address match.
// - timeout flag bit 4 sets in master mode on a timeout.
// - stretch flag bit 3 holds clock low until software clears it, or until an abort or disable.
// - receive-ready flag bit 2 sets when a byte arrives.
// - transmit-done flag bit 1 sets after the acknowledge is sampled.
// - start-seen flag bit 0 sets on start or repeated start.
// - software writing one sets bits 11,9,8,5,4,1,0 and can interrupt.
// - software writing one cannot set bits 7,6,3,2.
// - flags stay set until cleared; overrun clears by buffer read.
// - mask bit 11 gates the stop interrupt.
// - mask bits 9 to 0 gate the flags in the same positions.
// - mask bits 15 to 12 and 10 read zero and ignore writes.
// - status flags and mask clear to zero on reset; bit 10 still shows the clock level.
// - abort bit resets the controller, cleared by hardware or on disable.
// - general call address answered only with acceptance bit set.
// - stretch begins after fall 8 or fall 9 per stretch-point select.
// - master-select clears on address match, arbitration loss or a general call accepted with the acceptance bit set.
module isil_top
(
  input wire clk_sys_in,
  input wire resetn_in,
  input wire ce_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output wire [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  input wire scl_in,
  input wire sda_in,
  output wire scl_out,
  output wire scl_oe_out,
  input wire xfer_active_in,
  input wire ev_byte_rx_in,
  input wire [7:0] rx_byte_in,
  input wire ev_tx_ack_in,
  input wire ev_nack_in,
  input wire ev_arb_lost_in,
  input wire ev_addr_match_in,
  input wire ev_gen_call_in,
  input wire ev_timeout_in,
  output wire irq_out,
  output wire ctrl_reset_out,
  output wire master_select_out,
  output wire unit_enable_out,
  output wire [7:0] tx_byte_out,
  output wire tx_load_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // next value of one sticky flag; the hardware set is applied last
  function flag_upd;
    input cur;
    input hw_set;
    input wr;
    input wbit;
    input sw_set_ok;
    input sw_clr_ok;
    reg val;
    begin
      val = cur;
      if (wr && wbit && sw_set_ok)
        val = 1'b1;
      if (wr && !wbit && sw_clr_ok)
        val = 1'b0;
      flag_upd = val | hw_set;
    end
  endfunction
  // clock-fall count within a byte, wrapping after the acknowledge fall
  function [3:0] fall_next;
    input [3:0] cnt;
    begin
      if (cnt == `ISIL_FALLS_PER_BYTE)
        fall_next = 4'h1;
      else
        fall_next = cnt + 4'h1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link pins
  wire [1:0] pin_s;
  wire scl_s;
  wire sda_s;
  reg scl_p_q;
  reg sda_p_q;
  isil_sync u_sync
  (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .async_in({scl_in, sda_in}),
    .sync_out(pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  wire start_det;
  wire stop_det;
  wire scl_fall;
  // data may only move while the clock is high to mark start and stop
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_fall = scl_p_q & ~scl_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: address phase, one wait cycle, then the answer
  reg ph_wait_q;
  reg ph_write_q;
  reg ph_ok_q;
  reg [`ISIL_IDX_W-1:0] ph_idx_q;
  reg [31:0] hrdata_q;
  reg hreadyout_q;
  reg hresp_q;
  wire accept;
  wire addr_ok;
  wire wr_cyc;
  wire rd_cyc;
  wire wr_status;
  wire wr_mask;
  wire wr_ctrl;
  wire wr_buf;
  wire buf_read;
  assign accept = hsel_in & htrans_in[1] & hready_in;
  assign addr_ok = (haddr_in[31:7] == 25'h0) && (haddr_in[1:0] == 2'h0) &&
                   (hsize_in == `ISIL_HSIZE_WORD);
  assign wr_cyc = ph_wait_q & ph_write_q & ph_ok_q;
  assign rd_cyc = ph_wait_q & ~ph_write_q & ph_ok_q;
  assign wr_status = wr_cyc && (ph_idx_q == `ISIL_IDX_STATUS);
  assign wr_mask = wr_cyc && (ph_idx_q == `ISIL_IDX_MASK);
  assign wr_ctrl = wr_cyc && (ph_idx_q == `ISIL_IDX_CONTROL);
  assign wr_buf = wr_cyc && (ph_idx_q == `ISIL_IDX_BUFFER);
  assign buf_read = rd_cyc && (ph_idx_q == `ISIL_IDX_BUFFER);

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg [15:0] flags_q;
  reg [15:0] flags_d;
  reg [15:0] mask_q;
  reg [15:0] ctrl_q;
  reg [15:0] ctrl_d;
  reg bus_active_q;
  reg engaged_q;
  reg [3:0] fall_cnt_q;
  reg stretch_hold_q;
  reg [7:0] rx_data_q;
  reg rx_full_q;
  reg [7:0] tx_byte_q;
  reg tx_load_q;
  reg irq_q;
  reg abort_pulse_q;
  reg [15:0] hw_set;
  reg [15:0] rd_val;
  integer i;
  wire en;
  wire gc_hit;
  wire [3:0] stretch_at;
  wire stretch_point;
  assign en = ctrl_q[`ISIL_CT_ENABLE];
  assign gc_hit = en & ev_gen_call_in & ctrl_q[`ISIL_CT_GC_ACCEPT];
  assign stretch_at = ctrl_q[`ISIL_CT_STRETCH_SEL] ? `ISIL_STRETCH_AT_8 :
                      `ISIL_STRETCH_AT_9;
  // only a byte this unit takes part in is stretched
  assign stretch_point = en & ctrl_q[`ISIL_CT_STRETCH_ALLOW] & engaged_q &
                         ~ctrl_q[`ISIL_CT_ABORT] & scl_fall &
                         (fall_next(fall_cnt_q) == stretch_at);

  ////////////////////////////////////////////////////////////////////////////
  // flag events and flag update
  always @*
  begin
    hw_set = 16'h0000;
    hw_set[`ISIL_ST_STOP_SEEN] = stop_det;
    hw_set[`ISIL_ST_OVERRUN] = ev_byte_rx_in & rx_full_q & ~buf_read;
    hw_set[`ISIL_ST_GEN_CALL] = gc_hit;
    hw_set[`ISIL_ST_NOT_ACKED] = ev_nack_in;
    hw_set[`ISIL_ST_ARB_LOST] = ev_arb_lost_in & ctrl_q[`ISIL_CT_MASTER];
    hw_set[`ISIL_ST_ADDR_MATCH] = ev_addr_match_in;
    hw_set[`ISIL_ST_TIMEOUT] = ev_timeout_in & ctrl_q[`ISIL_CT_MASTER];
    hw_set[`ISIL_ST_STRETCH] = stretch_point;
    hw_set[`ISIL_ST_RX_READY] = ev_byte_rx_in;
    hw_set[`ISIL_ST_TX_DONE] = ev_tx_ack_in;
    hw_set[`ISIL_ST_START_SEEN] = start_det;
    if (!en)
      hw_set = 16'h0000;
    flags_d = 16'h0000;
    for (i = 0; i < 16; i = i + 1)
    begin
      flags_d[i] = flag_upd(flags_q[i], hw_set[i], wr_status, hwdata_in[i],
                            |((`ISIL_SW_SET_MASK >> i) & 16'h0001),
                            |((`ISIL_SW_CLR_MASK >> i) & 16'h0001)) &
                   (|((`ISIL_FLAG_MASK >> i) & 16'h0001));
    end
    // writing zero leaves overrun alone; only a buffer read clears it
    if (buf_read && !hw_set[`ISIL_ST_OVERRUN])
      flags_d[`ISIL_ST_OVERRUN] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits
  always @*
  begin
    ctrl_d = ctrl_q;
    // the abort has been handed to the engine; hardware drops it
    if (abort_pulse_q)
      ctrl_d[`ISIL_CT_ABORT] = 1'b0;
    if (wr_ctrl)
    begin
      // mode and enable are frozen while engaged, unless aborting
      if (engaged_q && !ctrl_q[`ISIL_CT_ABORT])
        ctrl_d = (hwdata_in[15:0] & `ISIL_CTRL_MASK & ~`ISIL_CTRL_LOCK) |
                 (ctrl_d & `ISIL_CTRL_LOCK);
      else
        ctrl_d = hwdata_in[15:0] & `ISIL_CTRL_MASK;
    end
    if ((en && (ev_arb_lost_in || ev_addr_match_in)) || gc_hit)
      ctrl_d[`ISIL_CT_MASTER] = 1'b0;
    if (!ctrl_d[`ISIL_CT_ENABLE])
      ctrl_d[`ISIL_CT_ABORT] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always @*
  begin
    rd_val = 16'h0000;
    case (ph_idx_q)
      `ISIL_IDX_STATUS:
      begin
        rd_val = flags_q & `ISIL_FLAG_MASK;
        rd_val[`ISIL_ST_BUS_ACTIVE] = bus_active_q;
        rd_val[`ISIL_ST_ENGAGED] = engaged_q;
        rd_val[`ISIL_ST_SCL_LEVEL] = scl_s;
      end
      `ISIL_IDX_MASK:
        rd_val = mask_q;
      `ISIL_IDX_CONTROL:
        rd_val = ctrl_q;
      `ISIL_IDX_BUFFER:
        rd_val = {8'h00, rx_data_q};
      default:
        rd_val = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      ph_wait_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_ok_q <= 1'b0;
      ph_idx_q <= {`ISIL_IDX_W{1'b0}};
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      flags_q <= `ISIL_STATUS_RST;
      mask_q <= `ISIL_MASK_RST;
      ctrl_q <= `ISIL_CTRL_RST;
      bus_active_q <= 1'b0;
      engaged_q <= 1'b0;
      fall_cnt_q <= 4'h0;
      stretch_hold_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_load_q <= 1'b0;
      irq_q <= 1'b0;
      abort_pulse_q <= 1'b0;
    end
    else if (ce_in)
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      hrdata_q <= 32'h00000000;
      // a transfer always costs one wait cycle, so a read never races a write
      if (ph_wait_q)
      begin
        ph_wait_q <= 1'b0;
        hreadyout_q <= 1'b1;
        hrdata_q <= rd_cyc ? {16'h0000, rd_val} : 32'h00000000;
      end
      else if (accept)
      begin
        ph_wait_q <= 1'b1;
        ph_write_q <= hwrite_in;
        ph_ok_q <= addr_ok;
        ph_idx_q <= haddr_in[`ISIL_IDX_W+1:2];
        hreadyout_q <= 1'b0;
      end
      flags_q <= flags_d;
      ctrl_q <= ctrl_d;
      if (wr_mask)
        mask_q <= hwdata_in[15:0] & `ISIL_FLAG_MASK;
      abort_pulse_q <= ctrl_q[`ISIL_CT_ABORT] & ~abort_pulse_q;
      if (!en)
        bus_active_q <= 1'b0;
      else if (start_det)
        bus_active_q <= 1'b1;
      else if (stop_det)
        bus_active_q <= 1'b0;
      engaged_q <= en & (xfer_active_in | stretch_hold_q |
                         (bus_active_q & ~ctrl_q[`ISIL_CT_MASTER]));
      if (start_det || !en)
        fall_cnt_q <= 4'h0;
      else if (scl_fall)
        fall_cnt_q <= fall_next(fall_cnt_q);
      // the line is released once software has cleared the flag, or on abort or disable
      stretch_hold_q <= en & ~ctrl_q[`ISIL_CT_ABORT] &
                        (stretch_point | (stretch_hold_q &
                         flags_d[`ISIL_ST_STRETCH]));
      if (ev_byte_rx_in && en)
      begin
        rx_data_q <= rx_byte_in;
        rx_full_q <= 1'b1;
      end
      else if (buf_read)
        rx_full_q <= 1'b0;
      // the transmit byte cannot change under a running transfer
      tx_load_q <= wr_buf & ~engaged_q;
      if (wr_buf && !engaged_q)
        tx_byte_q <= hwdata_in[7:0];
      irq_q <= |(flags_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata_out = hrdata_q;
  assign hreadyout_out = hreadyout_q;
  assign hresp_out = hresp_q;
  assign scl_out = 1'b0 & stretch_hold_q;
  assign scl_oe_out = stretch_hold_q;
  assign irq_out = irq_q;
  assign ctrl_reset_out = abort_pulse_q;
  assign master_select_out = ctrl_q[`ISIL_CT_MASTER];
  assign unit_enable_out = ctrl_q[`ISIL_CT_ENABLE];
  assign tx_byte_out = tx_byte_q;
  assign tx_load_out = tx_load_q;

endmodule

/* rtl/isil_regs.vh */
// register map, field positions, reset values and counts of the status/interrupt block
`ifndef ISIL_REGS_VH
`define ISIL_REGS_VH

// register indices; byte address is four times the index
`define ISIL_IDX_STATUS 5'h01
`define ISIL_IDX_CONTROL 5'h04
`define ISIL_IDX_BUFFER 5'h06
`define ISIL_IDX_MASK 5'h07
`define ISIL_IDX_W 5
`define ISIL_HSIZE_WORD 3'h2

// link_status fields
`define ISIL_ST_BUS_ACTIVE 15
`define ISIL_ST_ENGAGED 14
`define ISIL_ST_STOP_SEEN 11
`define ISIL_ST_SCL_LEVEL 10
`define ISIL_ST_OVERRUN 9
`define ISIL_ST_GEN_CALL 8
`define ISIL_ST_NOT_ACKED 7
`define ISIL_ST_ARB_LOST 6
`define ISIL_ST_ADDR_MATCH 5
`define ISIL_ST_TIMEOUT 4
`define ISIL_ST_STRETCH 3
`define ISIL_ST_RX_READY 2
`define ISIL_ST_TX_DONE 1
`define ISIL_ST_START_SEEN 0

// which status bits are sticky flags, and how software may touch them
`define ISIL_FLAG_MASK 16'h0bff
`define ISIL_SW_SET_MASK 16'h0b33
`define ISIL_SW_CLR_MASK 16'h09ff

// link_control fields
`define ISIL_CT_ABORT 15
`define ISIL_CT_STRETCH_ALLOW 9
`define ISIL_CT_GC_ACCEPT 8
`define ISIL_CT_STRETCH_SEL 4
`define ISIL_CT_MASTER 1
`define ISIL_CT_ENABLE 0
`define ISIL_CTRL_MASK 16'h83ff
`define ISIL_CTRL_LOCK 16'h0007

// reset values
`define ISIL_STATUS_RST 16'h0000
`define ISIL_MASK_RST 16'h0000
`define ISIL_CTRL_RST 16'h0000

// clock falls per byte on the link and the two stretch points
`define ISIL_FALLS_PER_BYTE 4'h9
`define ISIL_STRETCH_AT_8 4'h8
`define ISIL_STRETCH_AT_9 4'h9

`endif

/* rtl/isil_sync.v */
// two-flop synchroniser for the link pins
`timescale 1ns/1ps
module isil_sync
(
  input wire clk_sys_in,
  input wire resetn_in,
  input wire ce_in,
  input wire [1:0] async_in,
  output wire [1:0] sync_out
);

  reg [1:0] meta_q;
  reg [1:0] sync_q;

  // pins idle high on an open-drain bus
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end
    else if (ce_in)
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

/* verification/isil_top_sva.sv */
// port assertions for the status and interrupt block
`timescale 1ns/1ps
module isil_top_sva
(
  input logic clk_sys_in,
  input logic resetn_in,
  input logic hsel_in,
  input logic [1:0] htrans_in,
  input logic hready_in,
  input logic [31:0] hrdata_out,
  input logic hreadyout_out,
  input logic hresp_out,
  input logic scl_out,
  input logic scl_oe_out,
  input logic ev_arb_lost_in,
  input logic ev_addr_match_in,
  input logic ctrl_reset_out,
  input logic master_select_out,
  input logic unit_enable_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_take;
    hsel_in && htrans_in[1] && hready_in && hreadyout_out;
  endsequence
  sequence s_answer;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  a_ready_one_cycle: assert property (s_take |=> s_answer)
    else $error("ready not low for exactly one cycle");
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("error response seen");
  a_rdata_idle: assert property (hreadyout_out && $past(hreadyout_out) |-> hrdata_out == 32'h0)
    else $error("read data outside a data phase");
  a_upper_zero: assert property (hrdata_out[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_scl_low: assert property (scl_out == 1'b0)
    else $error("clock output level not low");
  // a stretch may only end through a register write, an abort or a disable
  a_stretch_release: assert property ($fell(scl_oe_out) |-> !$past(hreadyout_out) ||
    !$past(hreadyout_out, 2) || $past(ctrl_reset_out, 2) || !unit_enable_out)
    else $error("clock released without software");
  a_arb_drops_master: assert property (ev_arb_lost_in && unit_enable_out && hreadyout_out
    |=> !master_select_out) else $error("master kept after arbitration loss");
  a_match_drops_master: assert property (ev_addr_match_in && unit_enable_out && hreadyout_out
    |=> !master_select_out) else $error("master kept after address match");
  a_abort_pulse: assert property (ctrl_reset_out |=> !ctrl_reset_out)
    else $error("abort pulse longer than one cycle");
  a_disable_release: assert property (!unit_enable_out |=> !scl_oe_out)
    else $error("clock held while disabled");
endmodule
bind isil_top isil_top_sva u_sva (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .hsel_in(hsel_in), .htrans_in(htrans_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .ev_arb_lost_in(ev_arb_lost_in),
  .ev_addr_match_in(ev_addr_match_in), .ctrl_reset_out(ctrl_reset_out),
  .master_select_out(master_select_out), .unit_enable_out(unit_enable_out));

/* verification/isil_link_peer.sv */
// far-side bus master: start, nine clocks, stop, held back by a stretched clock
`timescale 1ns/1ps
module isil_link_peer
(
  input wire scl_wire_in,
  output logic scl_drv_out,
  output logic sda_drv_out,
  output logic busy_out
);
  // lines idle high through the pull-ups; the clock only runs inside a frame
  initial
  begin
    scl_drv_out = 1'b1;
    sda_drv_out = 1'b1;
    busy_out = 1'b0;
  end
  task automatic frame;
    int i;
    busy_out = 1'b1;
    sda_drv_out = 1'b0;
    #24;
    for (i = 0; i < 9; i++)
    begin
      scl_drv_out = 1'b0;
      #12;
      // data moves only mid-low so it never looks like a start or stop
      sda_drv_out = i[0];
      #12;
      scl_drv_out = 1'b1;
      wait (scl_wire_in === 1'b1);
      #24;
    end
    sda_drv_out = 1'b1;
    #24;
    busy_out = 1'b0;
  endtask
endmodule

/* verification/tb_top.sv */
// bench: bus accesses, engine event pulses and two link frames against expected values
`timescale 1ns/1ps
`include "isil_regs.vh"
module tb_top;
  localparam logic [31:0] A_ST = {`ISIL_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_CT = {`ISIL_IDX_CONTROL, 2'b00};
  localparam logic [31:0] A_BUF = {`ISIL_IDX_BUFFER, 2'b00};
  localparam logic [31:0] A_IE = {`ISIL_IDX_MASK, 2'b00};
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic xfer_active_in = 1'b0;
  logic [6:0] ev = 7'h0;
  logic [7:0] rx_byte_in = 8'h0;
  logic scl_drv;
  logic sda_drv;
  logic peer_busy;
  wire [31:0] hrdata_out;
  wire hready;
  wire scl_oe_out;
  wire irq_out;
  wire ctrl_reset_out;
  wire scl_wire = scl_drv & ~scl_oe_out;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int aborts = 0;
  int falls = 0;
  int f0;
  int i;
  int n;
  logic [31:0] r;
  logic [15:0] exp_st;
  int evs [8] = '{6, 1, 2, 0, 0, 3, 4, 5};
  int bits [8] = '{4, 1, 7, 2, 9, 6, 5, 8};
  always #2.5 clk_sys_in = ~clk_sys_in;
  isil_top DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(1'b1),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready), .hrdata_out(hrdata_out),
    .hreadyout_out(hready), .hresp_out(), .scl_in(scl_wire), .sda_in(sda_drv), .scl_out(),
    .scl_oe_out(scl_oe_out), .xfer_active_in(xfer_active_in), .ev_byte_rx_in(ev[0]),
    .rx_byte_in(rx_byte_in), .ev_tx_ack_in(ev[1]), .ev_nack_in(ev[2]),
    .ev_arb_lost_in(ev[3]), .ev_addr_match_in(ev[4]), .ev_gen_call_in(ev[5]),
    .ev_timeout_in(ev[6]), .irq_out(irq_out), .ctrl_reset_out(ctrl_reset_out),
    .master_select_out(), .unit_enable_out(), .tx_byte_out(), .tx_load_out());
  isil_link_peer peer (.scl_wire_in(scl_wire), .scl_drv_out(scl_drv), .sda_drv_out(sda_drv),
    .busy_out(peer_busy));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    hsize_in <= `ISIL_HSIZE_WORD;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    r = hrdata_out;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_sys_in);
    ev <= 7'h01 << b;
    @(posedge clk_sys_in);
    ev <= 7'h0;
  endtask
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clk_sys_in);
    chk({31'h0, irq_out}, {31'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (ctrl_reset_out === 1'b1)
      aborts++;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end
  // clock falls made by the far side, to see where a stretch begins
  always @(negedge scl_drv)
    falls++;
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    rd_chk(A_ST, 32'h0400);
    rd_chk(A_IE, 32'h0);
    wr(A_IE, 32'hffffffff);
    rd_chk(A_IE, 32'h0bff);
    wr(32'h08, 32'hffffffff);
    rd_chk(32'h08, 32'h0);
    wr(A_ST, 32'hffffffff);
    rd_chk(A_ST, 32'h0f33);
    irq_chk(1'b1);
    wr(A_ST, 32'h0);
    rd_chk(A_ST, 32'h0600);
    bus(1'b0, A_BUF, 32'h0);
    rd_chk(A_ST, 32'h0400);
    irq_chk(1'b0);
    wr(A_IE, 32'h0800);
    wr(A_ST, 32'h0001);
    irq_chk(1'b0);
    wr(A_ST, 32'h0800);
    irq_chk(1'b1);
    wr(A_IE, 32'h0);
    irq_chk(1'b0);
    wr(A_ST, 32'h0);
    wr(A_CT, 32'h0003);
    pulse(5);
    rd_chk(A_ST, 32'h0400);
    wr(A_CT, 32'h0303);
    rd_chk(A_CT, 32'h0303);
    exp_st = 16'h0400;
    for (i = 0; i < 8; i++)
    begin
      rx_byte_in <= 8'ha0 + 8'(i);
      pulse(evs[i]);
      exp_st = exp_st | (16'h1 << bits[i]);
      rd_chk(A_ST, {16'h0, exp_st});
    end
    rd_chk(A_CT, 32'h0301);
    wr(A_CT, 32'h0303);
    pulse(4);
    rd_chk(A_CT, 32'h0301);
    wr(A_CT, 32'h0303);
    pulse(5);
    rd_chk(A_CT, 32'h0301);
    wr(A_ST, 32'h0);
    rd_chk(A_ST, 32'h0600);
    rd_chk(A_BUF, 32'h00a4);
    rd_chk(A_ST, 32'h0400);
    // one frame per stretch point: after fall 9, then after fall 8
    for (i = 0; i < 2; i++)
    begin
      wr(A_ST, 32'h0);
      wr(A_CT, (i == 0) ? 32'h0301 : 32'h0311);
      f0 = falls;
      xfer_active_in <= 1'b1;
      fork
        peer.frame();
      join_none
      n = 0;
      while (scl_oe_out !== 1'b1 && n < 2000)
      begin
        @(posedge clk_sys_in);
        n++;
      end
      if (n == 2000)
        err_total++;
      chk(falls - f0, (i == 0) ? 9 : 8);
      repeat (4) @(posedge clk_sys_in);
      rd_chk(A_ST, 32'hc009);
      wr(A_ST, 32'h0);
      repeat (2) @(posedge clk_sys_in);
      chk({31'h0, scl_oe_out}, 32'h0);
      n = 0;
      while (peer_busy !== 1'b0 && n < 2000)
      begin
        @(posedge clk_sys_in);
        n++;
      end
      if (n == 2000)
        err_total++;
      repeat (8) @(posedge clk_sys_in);
      xfer_active_in <= 1'b0;
      rd_chk(A_ST, 32'h0c00);
    end
    wr(A_CT, 32'h8301);
    bus(1'b0, A_CT, 32'h0);
    chk({31'h0, r[15]}, 32'h0);
    chk(aborts, 1);
    conclude();
  end
endmodule
